/* File: hsls_pkg.sv */
package hsls_pkg;

	// APB register byte addresses.
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_STRAP  = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;

	// Control register fields and reset value.
	localparam int         CTRL_CONFIGURED_BIT = 0;
	localparam int         CTRL_SUSPENDED_BIT  = 1;
	localparam int         CTRL_LED_ENABLE_BIT = 2;
	localparam int         CTRL_WIDTH          = 3;
	localparam logic [2:0] CTRL_RESET          = 3'h0;

	// Strap register fields, all read only.
	localparam int STRAP_CODE_LSB      = 0;
	localparam int STRAP_FIXED_LSB     = 3;
	localparam int STRAP_MASK_LSB      = 5;
	localparam int STRAP_LED_LOW_BIT   = 9;
	localparam int STRAP_ENABLED_BIT   = 10;
	localparam int STRAP_CAPTURED_BIT  = 11;

	// Status register fields, all read only.
	localparam int STATUS_SELF_POWER_BIT = 0;
	localparam int STATUS_CLOCK_48_BIT   = 1;
	localparam int STATUS_SUPPLY_OK_BIT  = 2;
	localparam int STATUS_RUNNING_BIT    = 3;

	// Configuration method codes that the select straps may carry.
	localparam logic [2:0] CFG_DEFAULT_STRAPS  = 3'h0;
	localparam logic [2:0] CFG_SERIAL_SLAVE    = 3'h1;
	localparam logic [2:0] CFG_DEFAULT_STRAPS2 = 3'h2;
	localparam logic [2:0] CFG_EEPROM_LOAD     = 3'h3;

	// Fixed port masks for each two bit fixed port strap code.
	localparam logic [3:0] FIXED_MASK_NONE = 4'h0;
	localparam logic [3:0] FIXED_MASK_P1   = 4'h1;
	localparam logic [3:0] FIXED_MASK_P12  = 4'h3;
	localparam logic [3:0] FIXED_MASK_P123 = 4'h7;

	// Package variants in pins.
	localparam int PACKAGE_SMALL = 36;
	localparam int PACKAGE_LARGE = 48;

	// Synchroniser depth for every pin input.
	localparam int SYNC_STAGES = 2;

	// Timing: clock period and least external reset pulse.
	localparam int CLK_PERIOD_NS    = 4;
	localparam int RESET_MIN_NS     = 1000;
	localparam int RESET_MIN_CYCLES = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Sequencing states of the strap capture.
	typedef enum logic [1:0] {
		HSLS_HOLD,
		HSLS_CAPTURE,
		HSLS_RUN
	} hsls_state_type;

	// Strap values that are sampled together at reset release.
	typedef struct packed {
		logic [2:0] cfg_code;
		logic [1:0] fixed_strap;
	} hsls_strap_type;

endpackage

/* File: hsls_sync.sv */
`timescale 1ns/10ps

// Two flip-flop synchroniser, one chain per bit.
module hsls_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset.
	input  wire logic             clk,
	input  wire logic             rst_n,
	// Asynchronous levels in, synchronised levels out.
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	// First stage of every chain; read only by the second stage.
	logic [WIDTH-1:0] meta;

	// Refuse a width that has no bits.
	if (WIDTH < 1) begin : g_check
		$error("hsls_sync needs at least one bit.");
	end

	// Each bit passes two flops before any logic sees it.
	for (genvar i = 0; i < WIDTH; i++) begin : g_bit
		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				meta[i]     <= 1'b0;
				sync_out[i] <= 1'b0;
			end else begin
				meta[i]     <= async_in[i];
				sync_out[i] <= meta[i];
			end
		end
	end

endmodule

/* File: hsls_strap_latch.sv */
`timescale 1ns/10ps

// Holds the straps sampled at reset release until the next reset.
module hsls_strap_latch (
	// Clock and reset.
	input  wire logic                    clk,
	input  wire logic                    rst_n,
	// One-cycle capture strobe and the synchronised strap levels.
	input  wire logic                    capture,
	input  wire hsls_pkg::hsls_strap_type strap_in,
	// Held strap values and a flag that they are valid.
	output hsls_pkg::hsls_strap_type     strap_held,
	output logic                         captured
);

	// Straps are taken once; later pin changes are ignored.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			strap_held <= '0;
			captured   <= 1'b0;
		end else if (capture && !captured) begin // [R13]
			strap_held <= strap_in;
			captured   <= 1'b1;
		end
	end

endmodule

/* File: hsls_hub_strap_latch.sv */
`timescale 1ns/10ps

// Function
// [R1] Latch upper config select at reset release.
// [R2] Small package: upper select reads zero.
// [R3] Board holds reset low one microsecond; the bench holds its first reset only 10 cycles.
// [R4] Hold logic in reset until supplies stable.
// [R5] Indicator on only configured and not suspended.
// [R6] Sense low: bus power; high: local.
// [R7] Sample both fixed strap bits together.
// [R8] Decode fixed strap into fixed port mask.
// [R9] Strap codes 01, 11 make LED low.
// [R10] Clock select 0 is 24, 1 is 48.
// [R11] 48 MHz input only in large package.
// [R12] Code 001 serial slave, 011 EEPROM load.
// [R13] Latched straps hold until next reset.
module hsls_hub_strap_latch #(
	parameter int PACKAGE_PINS = hsls_pkg::PACKAGE_LARGE
) (
	// APB clock and reset; the reset is the device reset input.
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave request.
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	// APB slave answer.
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	// Supply monitor, high once all supplies are stable.
	input  wire logic        supply_good,
	// Configuration method select straps.
	input  wire logic        config_method_select_hi,
	input  wire logic        config_method_select_mid,
	input  wire logic        config_method_select_lo,
	// High fixed port strap, shared with the serial data pin.
	input  wire logic        fixed_port_strap_hi,
	// Shared indicator, power sense and low fixed strap pin.
	input  wire logic        activity_indicator_in,
	output logic             activity_indicator_out,
	output logic             activity_indicator_oe,
	// External clock rate select.
	input  wire logic        ext_clock_rate_select,
	// Latched configuration towards the hub core.
	output logic [2:0]       cfg_method_code,
	output logic             serial_slave_mode,
	output logic             eeprom_load_mode,
	output logic             straps_enabled,
	output logic [3:0]       fixed_port_mask,
	output logic             led_active_low,
	// Live status towards the hub core.
	output logic             clock_mode_48,
	output logic             self_power_present,
	output logic             hub_logic_ready
);

	// Pin levels after the synchroniser, in one vector.
	logic [6:0]               pins_sync;
	// Individual synchronised pins.
	logic                     supply_good_s;
	logic                     sel_hi_s;
	logic                     sel_mid_s;
	logic                     sel_lo_s;
	logic                     strap_hi_s;
	logic                     shared_pin_s;
	logic                     clock_sel_s;
	// Capture sequencer state and its next value.
	hsls_pkg::hsls_state_type state;
	hsls_pkg::hsls_state_type next_state;
	// Strap vector offered to the latch, and what it holds.
	hsls_pkg::hsls_strap_type strap_live;
	hsls_pkg::hsls_strap_type strap_held;
	// High once the straps are held.
	logic                     captured;
	// Straps are honoured for the held configuration code.
	logic                     strap_allowed;
	// Fixed strap as it applies, zero when straps are disabled.
	logic [1:0]               fixed_code;
	// Software control register.
	logic [2:0]               ctrl;
	// Recent drive enables; the synchronised pin lags the drive by two cycles.
	logic [1:0]               oe_history;
	// APB access phase qualifiers.
	logic                     apb_access;
	logic                     apb_write;
	// Read data and address check for the current address.
	logic [31:0]              next_rdata;
	logic                     addr_ok;

	// Refuse a package size the logic does not know.
	if (PACKAGE_PINS != hsls_pkg::PACKAGE_SMALL &&
	    PACKAGE_PINS != hsls_pkg::PACKAGE_LARGE) begin : g_check
		$error("PACKAGE_PINS must be 36 or 48.");
	end

	// Every pin input passes two flops before use.
	hsls_sync #(
		.WIDTH    (7)
	) u_sync (
		.clk      (pclk),
		.rst_n    (presetn),
		.async_in ({supply_good, config_method_select_hi, config_method_select_mid,
		            config_method_select_lo, fixed_port_strap_hi, activity_indicator_in,
		            ext_clock_rate_select}),
		.sync_out (pins_sync)
	);

	// Split the synchronised vector back into named levels.
	assign supply_good_s = pins_sync[6];
	assign sel_hi_s      = pins_sync[5];
	assign sel_mid_s     = pins_sync[4];
	assign sel_lo_s      = pins_sync[3];
	assign strap_hi_s    = pins_sync[2];
	assign shared_pin_s  = pins_sync[1];
	assign clock_sel_s   = pins_sync[0];

	// Assemble the straps; the small package has no upper select pin.
	always_comb begin
		strap_live = '0;
		if (PACKAGE_PINS == hsls_pkg::PACKAGE_LARGE) begin
			strap_live.cfg_code = {sel_hi_s, sel_mid_s, sel_lo_s}; // [R1]
		end else begin
			strap_live.cfg_code = {1'b0, sel_mid_s, sel_lo_s}; // [R2]
		end
		// Both fixed strap bits are taken in the same capture.
		strap_live.fixed_strap = {strap_hi_s, shared_pin_s}; // [R7]
	end

	// Sequencer: wait for stable supplies, capture once, then run.
	always_comb begin
		next_state = state;
		case (state)
			// Internal logic stays held while supplies settle.
			hsls_pkg::HSLS_HOLD: begin
				if (supply_good_s) begin // [R4]
					next_state = hsls_pkg::HSLS_CAPTURE;
				end
			end
			// One cycle in which the straps are sampled.
			hsls_pkg::HSLS_CAPTURE: begin
				next_state = hsls_pkg::HSLS_RUN;
			end
			// Normal operation; a supply drop returns to hold.
			hsls_pkg::HSLS_RUN: begin
				if (!supply_good_s) begin // [R4]
					next_state = hsls_pkg::HSLS_HOLD;
				end
			end
			default: begin
				next_state = hsls_pkg::HSLS_HOLD;
			end
		endcase
	end

	// Sequencer state register.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= hsls_pkg::HSLS_HOLD;
		end else begin
			state <= next_state;
		end
	end

	// The strap latch takes the straps only in the capture state.
	hsls_strap_latch u_latch (
		.clk        (pclk),
		.rst_n      (presetn),
		.capture    (state == hsls_pkg::HSLS_CAPTURE), // [R1]
		.strap_in   (strap_live),
		.strap_held (strap_held),
		.captured   (captured)
	);

	// Only the two default codes leave the pin straps in force.
	assign strap_allowed = (strap_held.cfg_code == hsls_pkg::CFG_DEFAULT_STRAPS) ||
	                       (strap_held.cfg_code == hsls_pkg::CFG_DEFAULT_STRAPS2);
	// A disabled strap counts as code 00.
	assign fixed_code    = strap_allowed ? strap_held.fixed_strap : 2'h0; // [R7]

	// Decoded configuration, registered towards the hub core.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_method_code   <= 3'h0;
			serial_slave_mode <= 1'b0;
			eeprom_load_mode  <= 1'b0;
			straps_enabled    <= 1'b0;
			fixed_port_mask   <= hsls_pkg::FIXED_MASK_NONE;
			led_active_low    <= 1'b0;
		end else begin
			cfg_method_code   <= strap_held.cfg_code; // [R1]
			// Serial slave for code 001, EEPROM load for code 011.
			serial_slave_mode <= captured &&
			                     strap_held.cfg_code == hsls_pkg::CFG_SERIAL_SLAVE; // [R12]
			eeprom_load_mode  <= captured &&
			                     strap_held.cfg_code == hsls_pkg::CFG_EEPROM_LOAD; // [R12]
			straps_enabled    <= captured && strap_allowed;
			// Ports fixed from port 1 upward.
			case (fixed_code)
				2'h0: begin
					fixed_port_mask <= hsls_pkg::FIXED_MASK_NONE; // [R8]
				end
				2'h1: begin
					fixed_port_mask <= hsls_pkg::FIXED_MASK_P1; // [R8]
				end
				2'h2: begin
					fixed_port_mask <= hsls_pkg::FIXED_MASK_P12; // [R8]
				end
				default: begin
					fixed_port_mask <= hsls_pkg::FIXED_MASK_P123; // [R8]
				end
			endcase
			// Odd strap codes make the indicator active low.
			led_active_low    <= fixed_code[0]; // [R9]
		end
	end

	// Shared pin: driven as indicator only when running and enabled.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			activity_indicator_oe  <= 1'b0;
			activity_indicator_out <= 1'b0;
			oe_history             <= 2'h0;
		end else begin
			// Remember the drive through both synchroniser stages.
			oe_history             <= {oe_history[0], activity_indicator_oe};
			activity_indicator_oe  <= (next_state == hsls_pkg::HSLS_RUN) &&
			                          ctrl[hsls_pkg::CTRL_LED_ENABLE_BIT];
			// Lit only while configured and not suspended, then polarity.
			activity_indicator_out <= (ctrl[hsls_pkg::CTRL_CONFIGURED_BIT] &&
			                           !ctrl[hsls_pkg::CTRL_SUSPENDED_BIT]) ^ // [R5]
			                          fixed_code[0]; // [R9]
		end
	end

	// Power sense is read from the shared pin while nothing drives it.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			self_power_present <= 1'b0;
		end else if (!activity_indicator_oe && oe_history == 2'h0 &&
		             state == hsls_pkg::HSLS_RUN) begin
			// The own drive level must have left the synchroniser first.
			// Low means bus powered, high means a local supply.
			self_power_present <= shared_pin_s; // [R6]
		end
	end

	// Clock rate mode; the small package runs at 24 MHz only.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clock_mode_48 <= 1'b0;
		end else if (PACKAGE_PINS == hsls_pkg::PACKAGE_LARGE) begin
			clock_mode_48 <= clock_sel_s; // [R10]
		end else begin
			clock_mode_48 <= 1'b0; // [R11]
		end
	end

	// Ready flag for the hub core, high once running.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hub_logic_ready <= 1'b0;
		end else begin
			hub_logic_ready <= (next_state == hsls_pkg::HSLS_RUN); // [R4]
		end
	end

	// Access phase, and a write at the edge that completes it.
	assign apb_access = psel && penable;
	assign apb_write  = apb_access && pready && pwrite;

	// Read mux and address decode for the current address.
	always_comb begin
		next_rdata = 32'h0;
		addr_ok    = 1'b1;
		case (paddr)
			hsls_pkg::ADDR_CTRL: begin
				next_rdata[hsls_pkg::CTRL_WIDTH-1:0] = ctrl;
			end
			hsls_pkg::ADDR_STRAP: begin
				next_rdata[hsls_pkg::STRAP_CODE_LSB +: 3]  = strap_held.cfg_code;
				next_rdata[hsls_pkg::STRAP_FIXED_LSB +: 2] = fixed_code;
				next_rdata[hsls_pkg::STRAP_MASK_LSB +: 4]  = fixed_port_mask;
				next_rdata[hsls_pkg::STRAP_LED_LOW_BIT]    = led_active_low;
				next_rdata[hsls_pkg::STRAP_ENABLED_BIT]    = straps_enabled;
				next_rdata[hsls_pkg::STRAP_CAPTURED_BIT]   = captured;
			end
			hsls_pkg::ADDR_STATUS: begin
				next_rdata[hsls_pkg::STATUS_SELF_POWER_BIT] = self_power_present;
				next_rdata[hsls_pkg::STATUS_CLOCK_48_BIT]   = clock_mode_48;
				next_rdata[hsls_pkg::STATUS_SUPPLY_OK_BIT]  = supply_good_s;
				next_rdata[hsls_pkg::STATUS_RUNNING_BIT]    = hub_logic_ready;
			end
			default: begin
				addr_ok = 1'b0;
			end
		endcase
	end

	// Answer one cycle into the access phase; error on unmapped address.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0;
		end else begin
			pready  <= apb_access && !pready;
			pslverr <= apb_access && !pready && !addr_ok;
			if (apb_access && !pready && !pwrite) begin
				prdata <= next_rdata;
			end
		end
	end

	// Control register; read-only addresses ignore writes.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= hsls_pkg::CTRL_RESET;
		end else if (apb_write && paddr == hsls_pkg::ADDR_CTRL) begin
			ctrl <= pwdata[hsls_pkg::CTRL_WIDTH-1:0];
		end
	end

endmodule

/* File: hsls_checker_sva.sv */
`timescale 1ns/10ps

// Checks handshake, decode and hold relations at the strap latch ports.
module hsls_checker_sva #(
	parameter int PACKAGE_PINS = 48
) (
	// Clock and reset.
	input wire logic       pclk,
	input wire logic       presetn,
	// Bus handshake.
	input wire logic       psel,
	input wire logic       penable,
	input wire logic       pready,
	input wire logic       pslverr,
	// Latched configuration.
	input wire logic [2:0] cfg_method_code,
	input wire logic       serial_slave_mode,
	input wire logic       eeprom_load_mode,
	input wire logic       straps_enabled,
	input wire logic [3:0] fixed_port_mask,
	input wire logic       led_active_low,
	// Live status and the shared pin.
	input wire logic       ext_clock_rate_select,
	input wire logic       clock_mode_48,
	input wire logic       activity_indicator_in,
	input wire logic       activity_indicator_oe,
	input wire logic       self_power_present,
	input wire logic       hub_logic_ready
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Decoded outputs are settled once ready has stood for two cycles.
	sequence settled_s;
		hub_logic_ready ##1 hub_logic_ready;
	endsequence
	AST_APB_ANSWER: assert property (psel && penable && !pready |=> pready)
		else $error("ready did not follow the access cycle");
	AST_READY_PULSE: assert property (pready |=> !pready)
		else $error("ready stood longer than one cycle");
	AST_ERR_WITH_READY: assert property (pslverr |-> pready)
		else $error("error without ready");
	AST_METHOD_DECODE: assert property (settled_s |-> serial_slave_mode ==
		(cfg_method_code == 3'h1) && eeprom_load_mode == (cfg_method_code == 3'h3))
		else $error("method decode wrong");
	AST_STRAPS_ON: assert property (settled_s |-> straps_enabled ==
		(cfg_method_code == 3'h0 || cfg_method_code == 3'h2))
		else $error("strap enable decode wrong");
	AST_MASK_SET: assert property (settled_s |-> fixed_port_mask inside
		{4'h0, 4'h1, 4'h3, 4'h7} && (straps_enabled || fixed_port_mask == 4'h0))
		else $error("fixed port mask wrong");
	AST_LED_POLARITY: assert property (settled_s |-> led_active_low ==
		(fixed_port_mask == 4'h1 || fixed_port_mask == 4'h7))
		else $error("led polarity wrong");
	AST_STRAPS_HELD: assert property (settled_s |=> $stable(cfg_method_code) &&
		$stable(fixed_port_mask) && $stable(led_active_low))
		else $error("latched straps changed");
	AST_SMALL_PACKAGE: assert property (PACKAGE_PINS == 36 && hub_logic_ready |->
		!cfg_method_code[2] && !clock_mode_48)
		else $error("small package select or clock wrong");
	AST_CLOCK_RATE: assert property ((hub_logic_ready && $stable(ext_clock_rate_select))[*5]
		|-> clock_mode_48 == (ext_clock_rate_select && PACKAGE_PINS == 48))
		else $error("clock rate mode wrong");
	AST_POWER_SENSE: assert property ((hub_logic_ready && !activity_indicator_oe &&
		$stable(activity_indicator_in))[*5] |-> self_power_present == activity_indicator_in)
		else $error("self power sense wrong");
	// Main scenarios that the bench should reach.
	COV_SERIAL: cover property (settled_s ##0 serial_slave_mode);
	COV_EEPROM: cover property (settled_s ##0 eeprom_load_mode);
	COV_BUS_ERR: cover property (pready && pslverr);
endmodule

bind hsls_hub_strap_latch hsls_checker_sva #(.PACKAGE_PINS(PACKAGE_PINS)) u_checker (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
	.pslverr(pslverr), .cfg_method_code(cfg_method_code),
	.serial_slave_mode(serial_slave_mode), .eeprom_load_mode(eeprom_load_mode),
	.straps_enabled(straps_enabled), .fixed_port_mask(fixed_port_mask),
	.led_active_low(led_active_low), .ext_clock_rate_select(ext_clock_rate_select),
	.clock_mode_48(clock_mode_48), .activity_indicator_in(activity_indicator_in),
	.activity_indicator_oe(activity_indicator_oe),
	.self_power_present(self_power_present), .hub_logic_ready(hub_logic_ready));

/* File: hsls_board_model.sv */
`timescale 1ns/10ps

// Board side: strap resistors, supply monitor, clock select and the shared LED pin.
module hsls_board_model (
	// Levels that the bench chooses for the board.
	input  wire logic [2:0] strap_code,
	input  wire logic       strap_fixed_hi,
	input  wire logic       pin_pull_level,
	input  wire logic       rate_select,
	input  wire logic       supplies_up,
	// Shared pin drive from the device.
	input  wire logic       led_drive,
	input  wire logic       led_drive_oe,
	// Pin levels seen by the device.
	output logic            sel_hi,
	output logic            sel_mid,
	output logic            sel_lo,
	output logic            fixed_hi,
	output logic            shared_pin,
	output logic            clk_rate,
	output logic            supply_ok
);
	// Select resistors set the configuration method.
	assign {sel_hi, sel_mid, sel_lo} = strap_code;
	assign fixed_hi = strap_fixed_hi;
	// The device overrides the resistor level only while it drives the LED.
	assign shared_pin = led_drive_oe ? led_drive : pin_pull_level;
	assign clk_rate = rate_select;
	assign supply_ok = supplies_up;
endmodule

/* File: tb_top.sv */
`timescale 1ns/10ps

// Self-checking bench for the strap latch and status block.
module tb_top;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd, e;
	logic [2:0]  code, cfg_method_code;
	logic [1:0]  fx;
	logic        pin_lvl, rate, sup, sel_hi, sel_mid, sel_lo, fixed_hi, shared_pin, clk_rate;
	logic        supply_ok, led_out, led_oe, serial_mode, eeprom_mode, straps_on, led_low;
	logic [3:0]  mask;
	logic        clock_48, self_power, ready;
	// Outputs of the small package instance that are compared.
	logic [2:0]  cfg_small;
	logic        clock_48_small;
	int          failures, cmp_count, seed, n;

	// Clock of 4 ns.
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end

	hsls_board_model board (.strap_code(code), .strap_fixed_hi(fx[1]),
		.pin_pull_level(pin_lvl), .rate_select(rate), .supplies_up(sup),
		.led_drive(led_out), .led_drive_oe(led_oe), .sel_hi(sel_hi), .sel_mid(sel_mid),
		.sel_lo(sel_lo), .fixed_hi(fixed_hi), .shared_pin(shared_pin),
		.clk_rate(clk_rate), .supply_ok(supply_ok));

	hsls_hub_strap_latch dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .supply_good(supply_ok),
		.config_method_select_hi(sel_hi), .config_method_select_mid(sel_mid),
		.config_method_select_lo(sel_lo), .fixed_port_strap_hi(fixed_hi),
		.activity_indicator_in(shared_pin), .activity_indicator_out(led_out),
		.activity_indicator_oe(led_oe), .ext_clock_rate_select(clk_rate),
		.cfg_method_code(cfg_method_code), .serial_slave_mode(serial_mode),
		.eeprom_load_mode(eeprom_mode), .straps_enabled(straps_on),
		.fixed_port_mask(mask), .led_active_low(led_low), .clock_mode_48(clock_48),
		.self_power_present(self_power), .hub_logic_ready(ready));

	// Small package instance on the same board and bus.
	hsls_hub_strap_latch #(.PACKAGE_PINS(hsls_pkg::PACKAGE_SMALL)) dut_small (.pclk(pclk),
		.presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
		.pwdata(pwdata), .pready(), .prdata(), .pslverr(), .supply_good(supply_ok),
		.config_method_select_hi(sel_hi), .config_method_select_mid(sel_mid),
		.config_method_select_lo(sel_lo), .fixed_port_strap_hi(fixed_hi),
		.activity_indicator_in(shared_pin), .activity_indicator_out(),
		.activity_indicator_oe(), .ext_clock_rate_select(clk_rate),
		.cfg_method_code(cfg_small), .serial_slave_mode(), .eeprom_load_mode(),
		.straps_enabled(), .fixed_port_mask(), .led_active_low(),
		.clock_mode_48(clock_48_small), .self_power_present(), .hub_logic_ready());

	// Prints the verdict and ends the run.
	task automatic wrap_up();
		if (failures == 0 && cmp_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// Compares one value and reports a mismatch.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// One bus transfer; read data and error are taken at the ready edge.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1) begin
			failures++;
			wrap_up();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Waits for the run state, then for the decoded outputs to settle.
	task automatic wait_ready();
		n = 0;
		while (ready !== 1'b1 && n < 100) begin
			@(posedge pclk);
			n++;
		end
		if (ready !== 1'b1) begin
			failures++;
			wrap_up();
		end
		repeat (3) @(posedge pclk);
	endtask

	// Expected strap register from the select code and the fixed strap.
	function automatic logic [31:0] exp_strap(input logic [2:0] c, input logic [1:0] f);
		logic       en;
		logic [1:0] af;
		logic [3:0] m;
		en = (c == 3'h0) || (c == 3'h2);
		af = en ? f : 2'h0;
		m = (af == 2'h0) ? 4'h0 : (af == 2'h1) ? 4'h1 : (af == 2'h2) ? 4'h3 : 4'h7;
		return {20'h0, 1'b1, en, af[0], m, af, c};
	endfunction

	// Main sequence: one reset per select code with random straps.
	initial begin
		seed = 10877;
		failures = 0;
		cmp_count = 0;
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{code, fx, pin_lvl, rate, sup} = 8'h01;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		// First release with the power-up straps: code 000, nothing fixed.
		wait_ready();
		e = exp_strap(code, fx);
		chk({20'h0, 1'b1, straps_on, led_low, mask, 2'h0, cfg_method_code}, e);
		for (int i = 0; i < 8; i++) begin
			presetn <= 1'b0;
			code <= i[2:0];
			fx <= 2'($random(seed));
			rate <= 1'($random(seed));
			sup <= (i != 3);
			@(posedge pclk);
			pin_lvl <= fx[0];
			repeat (hsls_pkg::RESET_MIN_CYCLES) @(posedge pclk);
			presetn <= 1'b1;
			if (i == 3) begin
				repeat (20) @(posedge pclk);
				chk(32'(ready), 32'h0);
				sup <= 1'b1;
			end
			wait_ready();
			e = exp_strap(code, fx);
			chk({20'h0, 1'b1, straps_on, led_low, mask, 2'h0, cfg_method_code}, e & ~32'h18);
			chk({30'h0, serial_mode, eeprom_mode}, {30'h0, code == 3'h1, code == 3'h3});
			chk({29'h0, cfg_small}, {29'h0, 1'b0, code[1:0]});
			apb(1'b0, hsls_pkg::ADDR_STRAP, 32'h0);
			chk(rd, e);
			apb(1'b1, hsls_pkg::ADDR_CTRL, {29'h0, 1'b1, i[1], i[0]});
			repeat (4) @(posedge pclk);
			chk({30'h0, led_oe, led_out}, {30'h0, 1'b1, (i[0] & ~i[1]) ^ e[9]});
			apb(1'b0, hsls_pkg::ADDR_CTRL, 32'h0);
			chk(rd, {29'h0, 1'b1, i[1], i[0]});
			apb(1'b1, hsls_pkg::ADDR_CTRL, 32'h0);
			code <= 3'($random(seed));
			fx <= 2'($random(seed));
			rate <= 1'($random(seed));
			pin_lvl <= 1'($random(seed));
			repeat (10) @(posedge pclk);
			chk({20'h0, 1'b1, straps_on, led_low, mask, 2'h0, cfg_method_code}, e & ~32'h18);
			chk({30'h0, clock_48, self_power}, {30'h0, rate, pin_lvl});
			chk({31'h0, clock_48_small}, 32'h0);
			apb(1'b0, hsls_pkg::ADDR_STATUS, 32'h0);
			chk(rd & 32'hF, {28'h0, 1'b1, 1'b1, rate, pin_lvl});
			apb(1'b1, hsls_pkg::ADDR_STRAP, 32'hFFFFFFFF);
			apb(1'b0, 8'h0C + {2'h0, 4'($random(seed)), 2'h0}, 32'h0);
			chk({31'h0, err}, 32'h1);
			chk(rd, 32'h0);
			apb(1'b0, hsls_pkg::ADDR_STRAP, 32'h0);
			chk({31'h0, err}, 32'h0);
			chk(rd, e);
		end
		wrap_up();
	end
endmodule
